// ### inc/rad_pkg.sv
// shared constants and carriers for the host register address decoder
package rad_pkg;

    // byte offsets of the transmit dma register map (register code times two)
    localparam logic [5:0]  RAD_OFF_DMA_COMMAND_ADDRESS        = 6'h00;
    localparam logic [5:0]  RAD_OFF_TRANSMIT_DMA_MODE          = 6'h02;
    localparam logic [5:0]  RAD_OFF_DMA_CONTROL                = 6'h06;
    localparam logic [5:0]  RAD_OFF_DMA_ARRAY_COUNT            = 6'h08;
    localparam logic [5:0]  RAD_OFF_BURST_DWELL_CONTROL        = 6'h12;
    localparam logic [5:0]  RAD_OFF_DMA_INTERRUPT_VECTOR       = 6'h14;
    localparam logic [5:0]  RAD_OFF_DMA_INTERRUPT_CONTROL      = 6'h18;
    localparam logic [5:0]  RAD_OFF_DMA_INTERRUPT_CLEAR        = 6'h1A;
    localparam logic [5:0]  RAD_OFF_DMA_INTERRUPT_SET          = 6'h1C;
    localparam logic [5:0]  RAD_OFF_TRANSMIT_DMA_INTERRUPT_ARM = 6'h1E;
    localparam logic [5:0]  RAD_OFF_TRANSMIT_BYTE_COUNT        = 6'h2A;
    localparam logic [5:0]  RAD_OFF_TRANSMIT_ADDRESS_LOW       = 6'h2C;
    localparam logic [5:0]  RAD_OFF_TRANSMIT_ADDRESS_HIGH      = 6'h2E;

    // one bit per implemented transmit-side dma register code
    localparam logic [31:0] RAD_DMA_MAP =
        (32'h1 << RAD_OFF_DMA_COMMAND_ADDRESS[5:1]) | (32'h1 << RAD_OFF_TRANSMIT_DMA_MODE[5:1]) |
        (32'h1 << RAD_OFF_DMA_CONTROL[5:1]) | (32'h1 << RAD_OFF_DMA_ARRAY_COUNT[5:1]) |
        (32'h1 << RAD_OFF_BURST_DWELL_CONTROL[5:1]) | (32'h1 << RAD_OFF_DMA_INTERRUPT_VECTOR[5:1]) |
        (32'h1 << RAD_OFF_DMA_INTERRUPT_CONTROL[5:1]) | (32'h1 << RAD_OFF_DMA_INTERRUPT_CLEAR[5:1]) |
        (32'h1 << RAD_OFF_DMA_INTERRUPT_SET[5:1]) | (32'h1 << RAD_OFF_TRANSMIT_DMA_INTERRUPT_ARM[5:1]) |
        (32'h1 << RAD_OFF_TRANSMIT_BYTE_COUNT[5:1]) | (32'h1 << RAD_OFF_TRANSMIT_ADDRESS_LOW[5:1]) |
        (32'h1 << RAD_OFF_TRANSMIT_ADDRESS_HIGH[5:1]);

    // reset values
    localparam logic [15:0] RAD_RST_REG   = 16'h0000;
    localparam logic [6:0]  RAD_RST_ADDR  = 7'h00;

    // field positions inside the address/command registers
    localparam int RAD_UL_POS   = 0;
    localparam int RAD_CODE_LSB = 1;
    localparam int RAD_BW_POS   = 6;
    localparam int RAD_RXTX_POS = 7;
    // multiplexed pins with shift right address clear use one bit higher
    localparam int RAD_NOSHIFT_LSB = 1;
    // separate address pins
    localparam int RAD_SEP_LSB  = 8;
    // register code bit that is ignored for the shared data register
    localparam int RAD_DATA_IGNORE_BIT = 3;
    localparam logic [4:0] RAD_CODE_CMD = 5'h00;

    // addressing triple: byte/word, register code, upper/lower
    typedef struct packed {
        logic       bw;
        logic [4:0] code;
        logic       ul;
    } rad_addr_t;

    // register selection handed to the rest of the device
    typedef struct packed {
        logic       serial;    // serial controller side when set, dma side when clear
        logic       rx;        // receive side dma register
        logic [4:0] code;      // register code field
        logic       wide;      // 16-bit transfer
        logic       upper;     // high byte of an 8-bit transfer
        logic       data_reg;  // shared receive/transmit data location
        logic       read;      // read cycle
    } rad_sel_t;

    // access phases
    typedef enum logic [1:0] {
        RAD_IDLE   = 2'b01,
        RAD_ACTIVE = 2'b10
    } rad_state_t;

endpackage

// ### tb/rad_host_model.sv
`timescale 1ns/100ps
// host processor side of the register port: chip select, strobes and the address/data lines
module rad_host_model (
    input  wire logic        clk_in,
    input  wire logic        access_in,  // device has taken the current cycle
    output logic             cs_n_out,
    output logic             as_n_out,
    output logic             ds_n_out,
    output logic             rd_n_out,
    output logic             wr_n_out,
    output logic             rnw_out,
    output logic [15:0]      lines_out,
    output int               n_late_out  // cycles that got no answer in time
);
    // idle bus: every strobe high
    initial begin
        {cs_n_out, as_n_out, ds_n_out, rd_n_out, wr_n_out, rnw_out} = 6'h3F;
        lines_out = 16'h0000;
        n_late_out = 0;
    end

    // one register cycle on read/write strobes, or on the data strobe with a direction line
    task cycle(input logic rd, input logic ds, input logic [15:0] val);
        int i;
        @(negedge clk_in);
        // callers keep upper/lower zero for words and give explicit low-byte data addresses
        lines_out = val;
        cs_n_out = 1'b0;
        if (ds) begin
            ds_n_out = 1'b0;
            rnw_out = rd;
        end else if (rd) begin
            rd_n_out = 1'b0;
        end else begin
            wr_n_out = 1'b0;
        end
        for (i = 0; i < 20 && access_in !== 1'b1; i++) @(negedge clk_in);
        if (access_in !== 1'b1) n_late_out++;
        // hold everything one more cycle so write data is sampled while still active
        @(negedge clk_in);
        {cs_n_out, ds_n_out, rd_n_out, wr_n_out} = 4'hF;
        // released lines must not keep showing the last value
        lines_out = ~val;
        repeat (4) @(negedge clk_in);
    endtask

    // address phase of a multiplexed cycle; trailing edge captures the address
    task addr_phase(input logic [15:0] val);
        @(negedge clk_in);
        lines_out = val;
        as_n_out = 1'b0;
        repeat (2) @(negedge clk_in);
        as_n_out = 1'b1;
        repeat (3) @(negedge clk_in);
    endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
// self-checking bench: host model drives the port, bench checks selection and data
module tb;
    import rad_pkg::*;
    logic        clk_in, nrst_in, cs_n, as_n, ds_n, rd_n, wr_n, rnw, sd, dc, wide, shift, sep;
    logic        oe, acc, tx_w, rx_r, seen, tx_seen, rx_seen, oe_seen;
    logic [15:0] lines, bus, dout, rx_data, tx_data, tx_d;
    rad_sel_t    sel;
    int          n_fail, n_checks, late, cycles;

    // device drives the lanes it owns while reading; separate mode keeps address lines on the host
    assign bus = oe ? (sep ? {lines[15:8], dout[7:0]} : dout) : lines;

    rad_register_address_decoder dut (.clk_in(clk_in), .nrst_in(nrst_in), .muxed_addr_data_in(bus),
        .muxed_addr_data_out(dout), .muxed_addr_data_oe_out(oe), .chip_select_n_in(cs_n),
        .address_strobe_n_in(as_n), .data_strobe_n_in(ds_n), .read_strobe_n_in(rd_n),
        .write_strobe_n_in(wr_n), .read_not_write_in(rnw), .serial_dma_sel_in(sd),
        .data_control_sel_in(dc), .wide_bus_setting_in(wide), .shift_right_address_in(shift),
        .separate_address_in(sep), .receive_data_in(rx_data), .sel_out(sel), .access_out(acc),
        .transmit_write_out(tx_w), .transmit_data_out(tx_data), .receive_read_out(rx_r),
        .strobe_seen_out(seen));
    rad_host_model host (.clk_in(clk_in), .access_in(acc), .cs_n_out(cs_n), .as_n_out(as_n),
        .ds_n_out(ds_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .rnw_out(rnw), .lines_out(lines),
        .n_late_out(late));

    // 20 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // catch the one-cycle data register pulses
    always @(posedge clk_in) begin
        if (tx_w === 1'b1) begin
            tx_seen <= 1'b1;
            tx_d <= tx_data;
        end
        if (rx_r === 1'b1) rx_seen <= 1'b1;
        if (oe === 1'b1) oe_seen <= 1'b1;
    end

    // hang guard: the whole sequence needs a few hundred cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            finish_test();
        end
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task finish_test();
        if (n_fail == 0 && n_checks > 0 && late == 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // selection word as a 16-bit value for comparison
    function automatic logic [15:0] s16();
        return {5'h00, sel};
    endfunction

    initial begin
        {n_fail, n_checks, cycles} = 0;
        {nrst_in, sd, dc, wide, shift, sep, tx_seen, rx_seen, oe_seen} = 9'h000;
        rx_data = 16'h5A69;
        tx_d = 16'h0000;
        repeat (20) @(negedge clk_in);
        nrst_in = 1'b1;
        chk({14'h0, seen, acc}, 16'h0000);
        // narrow bus, separate address: code on 13-9, upper/lower on 8, data on 7-0
        sep = 1'b1;
        host.cycle(0, 0, 16'h023C);
        chk(s16(), 16'h0010);
        chk({14'h0, oe_seen, oe}, 16'h0000);
        host.cycle(0, 0, 16'h43A5);
        host.cycle(1, 0, 16'h0200);
        chk(s16(), 16'h0011);
        chk(dout, 16'h003C);
        chk({14'h0, oe_seen, oe}, 16'h0002);
        host.cycle(1, 0, 16'h4300);
        chk(s16(), 16'h0015);
        chk(dout, 16'h00A5);
        host.cycle(0, 0, 16'h04FF);
        host.cycle(1, 0, 16'h0400);
        chk(dout, 16'h0000);
        // wide bus, no address strobe yet: implicit command register, then redirect
        {sep, wide} = 2'b01;
        host.cycle(0, 0, 16'h0002);
        chk(s16(), 16'h0008);
        host.cycle(0, 0, 16'hBEEF);
        chk(s16(), 16'h0018);
        host.cycle(1, 1, 16'h0000);
        chk(dout, 16'hBEEF);
        sd = 1'b1;
        host.cycle(0, 0, 16'h0000);
        chk(s16(), 16'h0408);
        // both selects high: data register, word and narrow widths
        dc = 1'b1;
        host.cycle(0, 0, 16'h1234);
        chk({15'h0, tx_seen}, 16'h0001);
        chk(tx_d, 16'h1234);
        host.cycle(1, 1, 16'h0000);
        chk({15'h0, rx_seen}, 16'h0001);
        chk(dout, 16'h5A69);
        wide = 1'b0;
        host.cycle(0, 1, 16'h9876);
        chk(tx_d, 16'h0076);
        // multiplexed cycles with address strobe, shifted layout
        {sd, dc, wide, shift} = 4'h3;
        host.addr_phase(16'h0006);
        host.cycle(0, 0, 16'h7788);
        chk(s16(), 16'h0038);
        chk({15'h0, seen}, 16'h0001);
        host.addr_phase(16'h0006);
        host.cycle(1, 0, 16'h0000);
        chk(dout, 16'h7788);
        // unshifted layout: code on 6-2, line 0 ignored
        shift = 1'b0;
        host.addr_phase(16'h000D);
        host.cycle(1, 0, 16'h0000);
        chk(s16(), 16'h0039);
        chk(dout, 16'h7788);
        // serial code 11000 still reaches the shared data register
        {sd, shift, tx_seen} = 3'b110;
        host.addr_phase(16'h0030);
        host.cycle(0, 0, 16'h4455);
        chk({15'h0, tx_seen}, 16'h0001);
        chk(tx_d, 16'h4455);
        // serial code 00001 is not implemented here: reads back zero
        host.addr_phase(16'h0002);
        host.cycle(1, 0, 16'h0000);
        chk(s16(), 16'h0419);
        chk(dout, 16'h0000);
        finish_test();
    end
endmodule

// ### verilog/rad_register_address_decoder.sv
`timescale 1ns/100ps
// Functional notes
// - shift right: muxed address from lines 6-0
// - separate address: lines 14-8 latched on strobes
// - serial indirect from serial command low seven
// - dma indirect from dma command low eight
// - register code from five-bit field
// - wide bus: byte/word bit picks width
// - narrow bus ignores byte/word bit
// - byte access: upper/lower picks byte
// - implicit dma command register access
// - implicit serial command register access
// - both selects high: data register access
// - data register ignores code bit three
// - command register redirects its own address
// - decode on chip select plus strobe
// - no shift: lines 7-1, line 0 ignored
// - separate: upper/lower line 8, code 13-9
module rad_register_address_decoder
    import rad_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic [15:0] muxed_addr_data_in,
    output logic      [15:0] muxed_addr_data_out,
    output logic             muxed_addr_data_oe_out,
    input  wire logic        chip_select_n_in,
    input  wire logic        address_strobe_n_in,
    input  wire logic        data_strobe_n_in,
    input  wire logic        read_strobe_n_in,
    input  wire logic        write_strobe_n_in,
    input  wire logic        read_not_write_in,
    input  wire logic        serial_dma_sel_in,
    input  wire logic        data_control_sel_in,
    input  wire logic        wide_bus_setting_in,
    input  wire logic        shift_right_address_in,
    input  wire logic        separate_address_in,
    input  wire logic [15:0] receive_data_in,
    output rad_sel_t         sel_out,
    output logic             access_out,
    output logic             transmit_write_out,
    output logic [15:0]      transmit_data_out,
    output logic             receive_read_out,
    output logic             strobe_seen_out
);

    // synchronised pins
    logic [15:0] s_ad;      // address/data lines
    logic        s_cs_n;    // chip select
    logic        s_as_n;    // address strobe
    logic        s_ds_n;    // data strobe
    logic        s_rd_n;    // read strobe
    logic        s_wr_n;    // write strobe
    logic        s_rnw;     // direction for data strobe cycles
    logic        s_sd;      // serial/dma select
    logic        s_dc;      // data/control select

    rad_sync #(.W(24)) u_sync (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .pin_in   ({muxed_addr_data_in, chip_select_n_in, address_strobe_n_in, data_strobe_n_in,
                    read_strobe_n_in, write_strobe_n_in, read_not_write_in, serial_dma_sel_in,
                    data_control_sel_in}),
        .sync_out ({s_ad, s_cs_n, s_as_n, s_ds_n, s_rd_n, s_wr_n, s_rnw, s_sd, s_dc})
    );

    // registers and state
    rad_state_t  state;           // access phase
    logic        prev_as_n;       // address strobe one cycle back
    logic        as_seen;         // address strobe activity since reset
    rad_addr_t   direct_addr;     // address captured from the pins
    logic [15:0] serial_cmd;      // serial_address_command
    logic [15:0] dma_mem [32];    // transmit-side dma registers, one word per code
    logic [15:0] wdata;           // last data seen on the lines while active
    rad_sel_t    sel;             // selection of the current access
    logic [15:0] rdata;           // read data driven onto the lines
    logic        access;          // one-cycle access start

    // combinational decode
    logic        active;          // chip select with a data-phase strobe
    logic        start;           // first cycle of an access
    logic        finish;          // strobes released in an access
    logic        as_rise;         // trailing edge of the address strobe
    logic        cyc_read;        // direction of the starting cycle
    logic        direct;          // pins carry the register address
    rad_addr_t   pin_addr;        // pin address for this access
    rad_addr_t   cmd_addr;        // indirect address from the selected command register
    logic [7:0]  cmd_low;         // low byte of the selected command register
    rad_sel_t    next_sel;        // selection for the starting access
    logic [15:0] next_rdata;      // read word for the starting access
    logic [15:0] dma_cmd;         // dma_address_command word

    assign dma_cmd = dma_mem[RAD_CODE_CMD];

    // split a seven bit field into byte/word, code and upper/lower
    function automatic rad_addr_t split_addr(input logic [6:0] raw);
        rad_addr_t a;
        a.bw   = raw[RAD_BW_POS];
        a.code = raw[RAD_CODE_LSB +: 5];
        a.ul   = raw[RAD_UL_POS];
        return a;
    endfunction

    // transmit-side dma code backed by storage
    function automatic logic dma_mapped(input logic rx, input logic [4:0] code);
        return !rx && RAD_DMA_MAP[code];
    endfunction

    // code that lands on the shared receive/transmit data location
    function automatic logic is_data_code(input logic [4:0] code);
        logic [4:0] m;
        m = code;
        m[RAD_DATA_IGNORE_BIT] = 1'b0;
        return m == 5'h10;
    endfunction

    // merge a byte or a word into an old register value
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d, input rad_sel_t s);
        if (s.wide)
            return d;
        else if (s.upper)
            return {d[7:0], old[7:0]};
        else
            return {old[15:8], d[7:0]};
    endfunction

    // an access needs chip select plus read, write or data strobe
    assign active   = !s_cs_n && (!s_ds_n || !s_rd_n || !s_wr_n);
    assign start    = (state == RAD_IDLE) && active;
    assign finish   = (state == RAD_ACTIVE) && !active;
    assign as_rise  = s_as_n && !prev_as_n;
    assign cyc_read = !s_rd_n || (s_wr_n && s_rnw);
    // pins address the register on a multiplexed bus or in separate address mode
    assign direct   = as_seen || separate_address_in;

    // without address strobe activity the separate lines are taken at the strobe
    always_comb begin
        if (separate_address_in && !as_seen)
            pin_addr = split_addr(s_ad[RAD_SEP_LSB +: 7]);
        else
            pin_addr = direct_addr;
    end

    // pick the command register that the serial/dma select points at
    always_comb begin
        cmd_low  = s_sd ? serial_cmd[7:0] : dma_cmd[7:0];
        cmd_addr = split_addr(cmd_low[6:0]);
    end

    // selection for a new access
    always_comb begin
        next_sel        = '0;
        next_sel.serial = s_sd;
        next_sel.read   = cyc_read;
        if (s_sd && s_dc) begin
            // implicit data register, low byte on a narrow bus
            next_sel.code     = 5'h10;
            next_sel.wide     = wide_bus_setting_in;
            next_sel.data_reg = 1'b1;
        end else if ((!direct || pin_addr.code == RAD_CODE_CMD) && cmd_low[5:0] == 6'h00) begin
            // implicit command register, sized by the bus width
            next_sel.code = RAD_CODE_CMD;
            next_sel.wide = wide_bus_setting_in;
        end else if (!direct || pin_addr.code == RAD_CODE_CMD) begin
            // indirect through the command register, also under direct addressing
            next_sel.code  = cmd_addr.code;
            next_sel.rx    = !s_sd && cmd_low[RAD_RXTX_POS];
            next_sel.wide  = wide_bus_setting_in && !cmd_addr.bw;
            next_sel.upper = !next_sel.wide && cmd_addr.ul;
        end else begin
            // direct from the pins, dma receive side selected by data/control
            next_sel.code  = pin_addr.code;
            next_sel.rx    = !s_sd && s_dc;
            next_sel.wide  = wide_bus_setting_in && !pin_addr.bw;
            next_sel.upper = !next_sel.wide && pin_addr.ul;
        end
        if (next_sel.serial && is_data_code(next_sel.code))
            next_sel.data_reg = 1'b1;
    end

    // read word for the new access, zero for unmapped codes
    always_comb begin
        logic [15:0] w;
        w = 16'h0000;
        if (next_sel.serial) begin
            if (next_sel.data_reg)
                w = receive_data_in;
            else if (next_sel.code == RAD_CODE_CMD)
                w = serial_cmd;
            else
                w = 16'h0000;
        end else if (next_sel.code == RAD_CODE_CMD) begin
            w = dma_cmd;  // dma command register answers for either side
        end else if (dma_mapped(next_sel.rx, next_sel.code)) begin
            w = dma_mem[next_sel.code];
        end else begin
            w = 16'h0000;
        end
        // byte reads always come back on the low lane
        if (next_sel.wide)
            next_rdata = w;
        else if (next_sel.upper)
            next_rdata = {8'h00, w[15:8]};
        else
            next_rdata = {8'h00, w[7:0]};
    end

    // access phase tracking
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
            state <= RAD_IDLE;
        else begin
            case (state)
                RAD_IDLE:   if (start) state <= RAD_ACTIVE;
                RAD_ACTIVE: if (!active) state <= RAD_IDLE;
                default:    state <= RAD_IDLE;
            endcase
        end
    end

    // address strobe detection, cleared only by reset
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prev_as_n <= 1'b1;
            as_seen   <= 1'b0;
        end else begin
            prev_as_n <= s_as_n;
            if (as_rise)
                as_seen <= 1'b1;
        end
    end

    // address capture at the trailing edge of the address strobe
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
            direct_addr <= RAD_RST_ADDR;  // packed triple takes the 7-bit reset word as is
        else if (as_rise) begin
            if (separate_address_in)
                direct_addr <= split_addr(s_ad[RAD_SEP_LSB +: 7]);
            else if (shift_right_address_in)
                direct_addr <= split_addr(s_ad[6:0]);
            else
                direct_addr <= split_addr(s_ad[RAD_NOSHIFT_LSB +: 7]);
        end
    end

    // selection and read data registered at the access start
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sel    <= '0;
            rdata  <= RAD_RST_REG;
            access <= 1'b0;
        end else begin
            access <= start;
            if (start) begin
                sel   <= next_sel;
                rdata <= next_rdata;
            end
        end
    end

    // data on the lines is sampled every cycle of the access after its start cycle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
            wdata <= RAD_RST_REG;
        else if (state == RAD_ACTIVE && active)
            wdata <= s_ad;
    end

    // register writes happen when the strobes release
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            serial_cmd <= RAD_RST_REG;
            for (int i = 0; i < 32; i++)
                dma_mem[i] <= RAD_RST_REG;
        end else if (finish && !sel.read) begin
            if (sel.serial && !sel.data_reg && sel.code == RAD_CODE_CMD)
                serial_cmd <= merge(serial_cmd, wdata, sel);
            else if (!sel.serial && sel.code == RAD_CODE_CMD)
                dma_mem[RAD_CODE_CMD] <= merge(dma_cmd, wdata, sel);
            else if (!sel.serial && dma_mapped(sel.rx, sel.code))
                dma_mem[sel.code] <= merge(dma_mem[sel.code], wdata, sel);
            // anything else is dropped
        end
    end

    // transmit data hand-off and receive read notice
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            transmit_write_out <= 1'b0;
            transmit_data_out  <= RAD_RST_REG;
            receive_read_out   <= 1'b0;
        end else begin
            transmit_write_out <= finish && !sel.read && sel.serial && sel.data_reg;
            receive_read_out   <= start && next_sel.read && next_sel.serial && next_sel.data_reg;
            if (finish && !sel.read && sel.serial && sel.data_reg)
                transmit_data_out <= sel.wide ? wdata : {8'h00, wdata[7:0]};
        end
    end

    // outputs; lines are driven only during a read access
    assign muxed_addr_data_out    = rdata;
    assign muxed_addr_data_oe_out = (state == RAD_ACTIVE) && sel.read && active;
    assign sel_out                = sel;
    assign access_out             = access;
    assign strobe_seen_out        = as_seen;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    a_narrow_no_word: assert property (access && !wide_bus_setting_in |-> !sel.wide)
        else $error("word transfer selected on a narrow bus");
    a_word_by_bw: assert property (start && direct && !(s_sd && s_dc) && pin_addr.code != RAD_CODE_CMD
        && wide_bus_setting_in |=> sel.wide == !$past(pin_addr.bw))
        else $error("width does not follow byte/word bit");
    a_implicit_data: assert property (start && s_sd && s_dc |=> sel.data_reg && !sel.upper
        && sel.wide == $past(wide_bus_setting_in))
        else $error("implicit data register access wrong");
    a_implicit_dma_address_command: assert property (start && !direct && !s_sd && dma_cmd[5:0] == 6'h00
        |=> !sel.serial && sel.code == RAD_CODE_CMD)
        else $error("implicit dma command register missed");
    a_data_bit_ignored: assert property (access && sel.serial && sel.code[4] && sel.code[2:0] == 3'h0
        |-> sel.data_reg)
        else $error("data register code not recognised");
    a_unmapped_zero: assert property (access && sel.read && sel.serial && !sel.data_reg
        && sel.code != RAD_CODE_CMD |-> rdata == 16'h0000)
        else $error("unmapped register read nonzero");
    a_shift_capture: assert property (as_rise && !separate_address_in && shift_right_address_in
        |=> direct_addr == $past(s_ad[6:0]))
        else $error("shift right address capture wrong");
    a_sep_capture: assert property (as_rise && separate_address_in
        |=> direct_addr == $past(s_ad[14:8]))
        else $error("separate address capture wrong");
    a_strobe_cause: assert property ($rose(as_seen) |-> $past(as_rise))
        else $error("address strobe detection without a strobe edge");
    a_access_needs_cs: assert property (access |-> $past(!s_cs_n))
        else $error("access without chip select");
    a_tx_one_pulse: assert property (transmit_write_out |=> !transmit_write_out)
        else $error("transmit write longer than one cycle");

    c_data_write: cover property (transmit_write_out);
    c_byte_upper: cover property (access && !sel.wide && sel.upper);
    c_indirect_dma: cover property (access && !sel.serial && sel.code != RAD_CODE_CMD && !as_seen);
    c_muxed_access: cover property (access && as_seen);

endmodule

// ### verilog/rad_sync.sv
`timescale 1ns/100ps
// two flop synchroniser for a group of pins
module rad_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta;  // first stage, read only by the second stage

    // both stages reset high so idle active-low strobes look released
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta     <= '1;
            sync_out <= '1;
        end else begin
            meta     <= pin_in;
            sync_out <= meta;
        end
    end
endmodule
